// file: common/flex_timer_pkg.sv
// Package: register map, field positions, reset values and carriers
package flex_timer_pkg;
  // Register word byte addresses (chosen map)
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_SYNC = 8'h04;
  localparam logic [7:0] OFS_MOD = 8'h08;
  localparam logic [7:0] OFS_CNTINIT = 8'h0c;
  localparam logic [7:0] OFS_COUNT = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_OUTPUT_INIT_LEVELS = 8'h18;
  localparam logic [7:0] OFS_OUTPUT_MASK_REGISTER = 8'h1c;
  localparam logic [7:0] OFS_CAPCTRL = 8'h20;
  localparam logic [7:0] OFS_CH0 = 8'h24;
  localparam logic [7:0] OFS_CH1 = 8'h28;
  localparam logic [7:0] OFS_WRITE_PROTECT_ENABLE_BIT = 8'h2c;
  // Mode register fields
  localparam int MODE_CAPTURE_TEST_ENABLE = 4;
  localparam int MODE_RESTRICT = 3;
  localparam int MODE_WRITE_PROTECT_DISABLE = 2;
  localparam int MODE_INIT = 1;
  localparam int MODE_EXTEN = 0;
  // Sync register fields
  localparam int SYNC_SWTRIG = 0;
  // Channel value word: bit 8 position, unused; channel reads return all 16 bits
  localparam int CH_HIBYTE = 8;
  // Reset values
  localparam logic [15:0] MOD_RST = 16'hffff;
  localparam logic [15:0] COUNTER_INITIAL_VALUE_RST = 16'h0000;
  localparam logic WRITE_PROTECT_DISABLE_RST = 1'b0;
  // Synchronisation targets carried together
  typedef struct packed {
    logic mod_cv;
    logic mask_cnt;
  } sync_sel_t;
  // Capture pair state carried together
  typedef struct packed {
    logic [15:0] buf_n;
    logic [15:0] buf_n1;
    logic [15:0] val_n;
    logic [15:0] val_n1;
  } cap_pair_t;
endpackage

// file: design/flex_timer_capture.sv
// Dual-edge capture pair with read-coherent buffers
`timescale 1ns/1ps
module flex_timer_capture (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic enable,
  input wire logic rise,
  input wire logic fall,
  input wire logic [15:0] count,
  input wire logic rd_ch_n,
  input wire logic cv_load,
  input wire logic [15:0] cv_n_wbuf,
  input wire logic [15:0] cv_n1_wbuf,
  output flex_timer_pkg::cap_pair_t pair
);
  import flex_timer_pkg::*;

  cap_pair_t pair_reg;
  cap_pair_t pair_next;

  // Edge captures; sync load of channel values only applies outside capture
  always_comb begin
    pair_next = pair_reg;
    if (enable) begin
      if (rise) begin
        pair_next.buf_n = count;
      end
      if (fall) begin
        pair_next.val_n = pair_reg.buf_n;
        pair_next.buf_n1 = count;
      end
      if (rd_ch_n) begin
        // Reading channel n first keeps the pair coherent
        pair_next.val_n1 = pair_reg.buf_n1;
      end
    end else if (cv_load) begin
      pair_next.val_n = cv_n_wbuf;
      pair_next.val_n1 = cv_n1_wbuf;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pair_reg <= '0;
    end else begin
      pair_reg <= pair_next;
    end
  end

  assign pair = pair_reg;

  a_fall_moves_buf: assert property (@(posedge clk) disable iff (!arst_n)
    enable && fall |=> pair_reg.val_n == $past(pair_reg.buf_n))
    else $error("falling edge did not move capture buffer");
  a_read_moves_next: assert property (@(posedge clk) disable iff (!arst_n)
    enable && rd_ch_n |=> pair_reg.val_n1 == $past(pair_reg.buf_n1))
    else $error("channel n read did not move next buffer");
endmodule

// file: design/flex_timer.sv
// Flexible 16-bit timer: mode control, counter, dual-edge capture
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ps
module flex_timer #(
  parameter int CHANNELS = 2
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ch_in_pin,
  input wire logic hw_trigger,
  output logic [CHANNELS-1:0] ch_out,
  output logic [15:0] count_value,
  output logic signed_mode,
  output logic capture_test
);
  import flex_timer_pkg::*;

  initial begin
    if (CHANNELS != 2) $error("one capture pair needs CHANNELS of 2");
  end

  // Mode and control registers
  logic capture_test_enable_reg, capture_test_enable_next;
  logic restrict_reg, restrict_next;
  logic write_protect_disable_reg, write_protect_disable_next;
  logic write_protect_enable_bit_seen_reg, write_protect_enable_bit_seen_next;
  logic exten_reg, exten_next;
  logic capen_reg, capen_next;
  logic tof_reg, tof_next;
  logic [15:0] mod_reg, mod_next, mod_wbuf_reg, mod_wbuf_next;
  logic [15:0] counter_initial_value_reg, counter_initial_value_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [CHANNELS-1:0] oinit_reg, oinit_next;
  logic [CHANNELS-1:0] mask_reg, mask_next, mask_wbuf_reg, mask_wbuf_next;
  logic [CHANNELS-1:0] out_reg, out_next;
  logic [15:0] cv0_wbuf_reg, cv0_wbuf_next, cv1_wbuf_reg, cv1_wbuf_next;
  logic [31:0] rdata_reg, rdata_next;
  logic sw_trig;
  sync_sel_t sel;
  logic wr, rd;
  logic in_s1_reg, in_s2_reg, in_d_reg, trg_s1_reg, trg_s2_reg, trg_d_reg;
  logic rise, fall, hw_pulse, rd_ch0;
  cap_pair_t pair;

  // Two-flop synchronisers; edges detected after the second stage only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      in_s1_reg <= 1'b0;
      in_s2_reg <= 1'b0;
      in_d_reg <= 1'b0;
      trg_s1_reg <= 1'b0;
      trg_s2_reg <= 1'b0;
      trg_d_reg <= 1'b0;
    end else begin
      in_s1_reg <= ch_in_pin;
      in_s2_reg <= in_s1_reg;
      in_d_reg <= in_s2_reg;
      trg_s1_reg <= hw_trigger;
      trg_s2_reg <= trg_s1_reg;
      trg_d_reg <= trg_s2_reg;
    end
  end

  assign rise = in_s2_reg & ~in_d_reg;
  assign fall = ~in_s2_reg & in_d_reg;
  assign hw_pulse = trg_s2_reg & ~trg_d_reg;

  // APB: zero wait states, every access completes in its access phase
  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign sw_trig = wr && paddr == OFS_SYNC && pwdata[SYNC_SWTRIG];
  assign rd_ch0 = rd && paddr == OFS_CH0;

  // Trigger routing: restrict splits sources between targets
  always_comb begin
    if (restrict_reg) begin
      sel.mod_cv = sw_trig;
      sel.mask_cnt = hw_pulse;
    end else begin
      sel.mod_cv = sw_trig | hw_pulse;
      sel.mask_cnt = sw_trig | hw_pulse;
    end
  end

  // Register writes, counter and flags
  always_comb begin
    capture_test_enable_next = capture_test_enable_reg;
    restrict_next = restrict_reg;
    write_protect_disable_next = write_protect_disable_reg;
    write_protect_enable_bit_seen_next = write_protect_enable_bit_seen_reg;
    exten_next = exten_reg;
    capen_next = capen_reg;
    tof_next = tof_reg;
    mod_next = mod_reg;
    mod_wbuf_next = mod_wbuf_reg;
    counter_initial_value_next = counter_initial_value_reg;
    oinit_next = oinit_reg;
    mask_next = mask_reg;
    mask_wbuf_next = mask_wbuf_reg;
    out_next = out_reg;
    cv0_wbuf_next = cv0_wbuf_reg;
    cv1_wbuf_next = cv1_wbuf_reg;
    // Counter: wrap from modulo back to initial value
    if (cnt_reg == mod_reg) begin
      cnt_next = counter_initial_value_reg;
      tof_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + 16'h0001;
    end
    // Enable bit reads as inverse of disable; a read of one arms the set
    if (rd && paddr == OFS_WRITE_PROTECT_ENABLE_BIT && !write_protect_disable_reg) begin
      write_protect_enable_bit_seen_next = 1'b1;
    end
    if (wr) begin
      case (paddr)
        OFS_MODE: begin
          if (write_protect_disable_reg) begin
            capture_test_enable_next = pwdata[MODE_CAPTURE_TEST_ENABLE];
            exten_next = pwdata[MODE_EXTEN];
          end
          restrict_next = pwdata[MODE_RESTRICT];
          if (pwdata[MODE_WRITE_PROTECT_DISABLE] && write_protect_enable_bit_seen_reg) begin
            write_protect_disable_next = 1'b1;
            write_protect_enable_bit_seen_next = 1'b0;
          end
          if (pwdata[MODE_INIT]) begin
            out_next = oinit_reg;
          end
        end
        OFS_WRITE_PROTECT_ENABLE_BIT: begin
          if (pwdata[0]) begin
            write_protect_disable_next = 1'b0;
            write_protect_enable_bit_seen_next = 1'b0;
          end
        end
        OFS_MOD: mod_wbuf_next = pwdata[15:0];
        OFS_CNTINIT: begin
          if (exten_reg) begin
            counter_initial_value_next = pwdata[15:0];
          end
        end
        OFS_STATUS: begin
          // Write one to clear; a wrap in the same cycle wins
          if (pwdata[0] && !(cnt_reg == mod_reg)) begin
            tof_next = 1'b0;
          end
        end
        OFS_OUTPUT_INIT_LEVELS: oinit_next = pwdata[CHANNELS-1:0];
        OFS_OUTPUT_MASK_REGISTER: begin
          if (exten_reg) begin
            mask_wbuf_next = pwdata[CHANNELS-1:0];
          end
        end
        OFS_CAPCTRL: begin
          if (exten_reg) begin
            capen_next = pwdata[0];
          end
        end
        OFS_CH0: cv0_wbuf_next = pwdata[15:0];
        OFS_CH1: cv1_wbuf_next = pwdata[15:0];
        default: begin
        end
      endcase
    end
    // Synchronised buffer loads
    if (sel.mod_cv) begin
      mod_next = mod_wbuf_next;
    end
    if (sel.mask_cnt) begin
      mask_next = mask_wbuf_next;
      cnt_next = counter_initial_value_reg;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      capture_test_enable_reg <= 1'b0;
      restrict_reg <= 1'b0;
      write_protect_disable_reg <= WRITE_PROTECT_DISABLE_RST;
      write_protect_enable_bit_seen_reg <= 1'b0;
      exten_reg <= 1'b0;
      capen_reg <= 1'b0;
      tof_reg <= 1'b0;
      mod_reg <= MOD_RST;
      mod_wbuf_reg <= MOD_RST;
      counter_initial_value_reg <= COUNTER_INITIAL_VALUE_RST;
      cnt_reg <= COUNTER_INITIAL_VALUE_RST;
      oinit_reg <= '0;
      mask_reg <= '0;
      mask_wbuf_reg <= '0;
      out_reg <= '0;
      cv0_wbuf_reg <= 16'h0000;
      cv1_wbuf_reg <= 16'h0000;
    end else begin
      capture_test_enable_reg <= capture_test_enable_next;
      restrict_reg <= restrict_next;
      write_protect_disable_reg <= write_protect_disable_next;
      write_protect_enable_bit_seen_reg <= write_protect_enable_bit_seen_next;
      exten_reg <= exten_next;
      capen_reg <= capen_next;
      tof_reg <= tof_next;
      mod_reg <= mod_next;
      mod_wbuf_reg <= mod_wbuf_next;
      counter_initial_value_reg <= counter_initial_value_next;
      cnt_reg <= cnt_next;
      oinit_reg <= oinit_next;
      mask_reg <= mask_next;
      mask_wbuf_reg <= mask_wbuf_next;
      out_reg <= out_next;
      cv0_wbuf_reg <= cv0_wbuf_next;
      cv1_wbuf_reg <= cv1_wbuf_next;
    end
  end

  flex_timer_capture u_capture (
    .clk(clk),
    .arst_n(arst_n),
    .enable(capen_reg),
    .rise(rise),
    .fall(fall),
    .count(cnt_reg),
    .rd_ch_n(rd_ch0),
    .cv_load(sel.mod_cv),
    .cv_n_wbuf(cv0_wbuf_reg),
    .cv_n1_wbuf(cv1_wbuf_reg),
    .pair(pair)
  );

  // Read mux; init bit always reads zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        OFS_MODE: rdata_next = {27'h0, capture_test_enable_reg, restrict_reg, write_protect_disable_reg,
          1'b0, exten_reg};
        OFS_MOD: rdata_next = {16'h0, mod_reg};
        OFS_CNTINIT: rdata_next = {16'h0, counter_initial_value_reg};
        OFS_COUNT: rdata_next = {16'h0, cnt_reg};
        OFS_STATUS: rdata_next = {31'h0, tof_reg};
        OFS_OUTPUT_INIT_LEVELS: rdata_next = {{(32-CHANNELS){1'b0}}, oinit_reg};
        OFS_OUTPUT_MASK_REGISTER: rdata_next = {{(32-CHANNELS){1'b0}}, mask_reg};
        OFS_CAPCTRL: rdata_next = {31'h0, capen_reg};
        OFS_CH0: rdata_next = {16'h0, pair.val_n};
        OFS_CH1: rdata_next = {16'h0, pair.val_n1};
        OFS_WRITE_PROTECT_ENABLE_BIT: rdata_next = {31'h0, ~write_protect_disable_reg};
        default: rdata_next = 32'h0000_0000;
      endcase
    end else begin
      rdata_next = rdata_reg;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign prdata = rdata_reg;
  assign pslverr = 1'b0;
  // Masked channels are forced low
  assign ch_out = out_reg & ~mask_reg;
  assign count_value = cnt_reg;
  assign signed_mode = counter_initial_value_reg[15];
  assign capture_test = capture_test_enable_reg;

  a_protect_capture_test_enable: assert property (@(posedge clk) disable iff (!arst_n)
    wr && paddr == OFS_MODE && !write_protect_disable_reg |=> $stable(capture_test_enable_reg))
    else $error("protected bit changed while protected");
  a_write_protect_enable_bit_clears: assert property (@(posedge clk) disable iff (!arst_n)
    wr && paddr == OFS_WRITE_PROTECT_ENABLE_BIT && pwdata[0] |=> !write_protect_disable_reg)
    else $error("enable write did not clear disable");
  a_write_protect_disable_needs_read: assert property (@(posedge clk) disable iff (!arst_n)
    !write_protect_disable_reg && !write_protect_enable_bit_seen_reg |=> !write_protect_disable_reg)
    else $error("disable set without prior read");
  a_init_drives: assert property (@(posedge clk) disable iff (!arst_n)
    wr && paddr == OFS_MODE && pwdata[MODE_INIT]
    |=> out_reg == $past(oinit_reg))
    else $error("init did not load output levels");
  a_exten_protect: assert property (@(posedge clk) disable iff (!arst_n)
    !write_protect_disable_reg |=> $stable(exten_reg))
    else $error("extended enable changed while protected");
  a_wrap_sets_tof: assert property (@(posedge clk) disable iff (!arst_n)
    cnt_reg == mod_reg && !sel.mask_cnt
    |=> tof_reg && cnt_reg == $past(counter_initial_value_reg))
    else $error("wrap did not set overflow");
  a_sync_loads: assert property (@(posedge clk) disable iff (!arst_n)
    sel.mask_cnt |=> cnt_reg == $past(counter_initial_value_reg))
    else $error("sync did not reinitialise counter");
  a_restrict_route: assert property (@(posedge clk) disable iff (!arst_n)
    restrict_reg && hw_pulse && !sw_trig |-> !sel.mod_cv)
    else $error("hardware trigger reached modulo in restricted mode");
  a_count_step: assert property (@(posedge clk) disable iff (!arst_n)
    cnt_reg != mod_reg && !sel.mask_cnt
    |=> cnt_reg == $past(cnt_reg) + 16'h0001)
    else $error("counter did not step by one");
endmodule

// file: verification/chan_pin_model.sv
// Channel input pin model for the capture inputs
`timescale 1ns/1ps
module chan_pin_model (
  input wire logic clk,
  output logic pin
);
  // Pin idles low until a scenario asks for an edge
  initial pin = 1'b0;

  // Change the level just after an edge, then let the synchroniser settle
  task automatic drive(input logic level, input int settle);
    @(posedge clk);
    pin <= level;
    repeat (settle) @(posedge clk);
  endtask
endmodule

// file: verification/tb.sv
// Self-checking bench for the flexible timer
`timescale 1ns/1ps
module tb;
  import flex_timer_pkg::*;
  typedef struct packed {logic [31:0] e; logic [31:0] m;} note_t;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic hw_trigger = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ch_in_pin;
  logic [1:0] ch_out;
  logic [15:0] count_value;
  logic signed_mode;
  logic capture_test;
  note_t notes[$];
  note_t nt;
  int mismatches = 0;
  int check_count = 0;
  logic [15:0] m;
  logic [15:0] v [4];
  logic [1:0] o;

  // 20 MHz clock
  always #25 clk = ~clk;

  flex_timer #(.CHANNELS(2)) u_dut (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ch_in_pin(ch_in_pin),
    .hw_trigger(hw_trigger), .ch_out(ch_out), .count_value(count_value),
    .signed_mode(signed_mode), .capture_test(capture_test)
  );

  chan_pin_model u_pin (.clk(clk), .pin(ch_in_pin));

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask

  // One APB transfer; reads leave their expectation in the queue
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input note_t n);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    if (!wr) notes.push_back(n);
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 64);
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 64) begin
      mismatches++;
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, '0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] msk);
    apb(1'b0, a, 32'h0, '{e: e, m: msk});
  endtask

  // Cycles from one visit of st to the next one is the period
  task automatic per(input logic [15:0] st, input int len);
    int n;
    n = 0;
    while (count_value !== st && n < 300) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    n = 1;
    while (count_value !== st && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk(n, len);
  endtask

  // Async trigger held long enough to cross the synchroniser
  task automatic hw_pulse();
    @(posedge clk);
    hw_trigger <= 1'b1;
    repeat (4) @(posedge clk);
    hw_trigger <= 1'b0;
    repeat (8) @(posedge clk);
  endtask

  // Modulo equal to the initial count freezes the counter at val
  task automatic setc(input logic [15:0] val);
    wr(OFS_CNTINIT, {16'h0, val});
    wr(OFS_MOD, {16'h0, val});
    wr(OFS_SYNC, 32'h1);
    repeat (2) @(negedge clk);
    chk({16'h0, count_value}, {16'h0, val});
  endtask

  // Read results are compared oldest note first as they appear
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) begin
      if (notes.size() == 0) begin
        $display("[FAIL] t=%0t got=%h exp=none", $time, prdata);
        mismatches++;
      end else begin
        nt = notes.pop_front();
        chk(prdata & nt.m, nt.e & nt.m);
        chk({31'h0, pslverr}, 32'h0);
      end
    end
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    void'($urandom(32'h939b0492));
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    rd(OFS_MODE, 32'h0, 32'hff);
    wr(OFS_CNTINIT, 32'h1234);
    rd(OFS_CNTINIT, 32'h0, 32'hffff);
    wr(OFS_MODE, 32'h15);
    rd(OFS_MODE, 32'h0, 32'h1f);
    rd(8'h30, 32'h0, 32'hffffffff);
    rd(OFS_WRITE_PROTECT_ENABLE_BIT, 32'h1, 32'h1);
    wr(OFS_MODE, 32'h04);
    wr(OFS_MODE, 32'h15);
    rd(OFS_MODE, 32'h15, 32'h1f);
    rd(OFS_WRITE_PROTECT_ENABLE_BIT, 32'h0, 32'h1);
    @(negedge clk);
    chk({31'h0, capture_test}, 32'h1);
    wr(OFS_MODE, 32'h11);
    rd(OFS_MODE, 32'h15, 32'h1f);
    wr(OFS_WRITE_PROTECT_ENABLE_BIT, 32'h1);
    wr(OFS_MODE, 32'h00);
    rd(OFS_MODE, 32'h11, 32'h1f);
    rd(OFS_WRITE_PROTECT_ENABLE_BIT, 32'h1, 32'h1);
    wr(OFS_MODE, 32'h05);
    wr(OFS_MODE, 32'h05);
    rd(OFS_MODE, 32'h05, 32'h1f);
    @(negedge clk);
    chk({31'h0, capture_test}, 32'h0);
    $display("test protect done");
    m = 16'h20 + 16'($urandom % 64);
    wr(OFS_CNTINIT, 32'h0);
    wr(OFS_MOD, {16'h0, m});
    wr(OFS_SYNC, 32'h1);
    per(16'h0, int'(m) + 1);
    wr(OFS_STATUS, 32'h1);
    rd(OFS_STATUS, 32'h0, 32'h1);
    per(16'h0, int'(m) + 1);
    rd(OFS_STATUS, 32'h1, 32'h1);
    wr(OFS_CNTINIT, 32'hfff8);
    @(negedge clk);
    chk({31'h0, signed_mode}, 32'h1);
    wr(OFS_SYNC, 32'h1);
    per(16'hfff8, int'(m) + 9);
    wr(OFS_CNTINIT, 32'h3);
    @(negedge clk);
    chk({31'h0, signed_mode}, 32'h0);
    wr(OFS_SYNC, 32'h1);
    per(16'h3, int'(m) - 2);
    $display("test counter done");
    wr(OFS_MODE, 32'h0d);
    wr(OFS_MOD, 32'h10);
    hw_pulse();
    per(16'h3, int'(m) - 2);
    wr(OFS_SYNC, 32'h1);
    hw_pulse();
    per(16'h3, 14);
    wr(OFS_MODE, 32'h05);
    wr(OFS_MOD, {16'h0, m});
    hw_pulse();
    per(16'h3, int'(m) - 2);
    $display("test trigger done");
    o = 2'($urandom);
    wr(OFS_OUTPUT_INIT_LEVELS, {30'h0, o});
    wr(OFS_OUTPUT_MASK_REGISTER, 32'h0);
    wr(OFS_SYNC, 32'h1);
    wr(OFS_MODE, 32'h07);
    @(negedge clk);
    chk({30'h0, ch_out}, {30'h0, o});
    rd(OFS_MODE, 32'h05, 32'h1f);
    wr(OFS_OUTPUT_MASK_REGISTER, 32'h1);
    @(negedge clk);
    chk({30'h0, ch_out}, {30'h0, o});
    wr(OFS_SYNC, 32'h1);
    @(negedge clk);
    chk({30'h0, ch_out}, {30'h0, o & 2'b10});
    $display("test init done");
    wr(OFS_CAPCTRL, 32'h1);
    for (int i = 0; i < 4; i++) v[i] = 16'($urandom);
    setc(v[0]);
    u_pin.drive(1'b1, 8);
    setc(v[1]);
    u_pin.drive(1'b0, 8);
    rd(OFS_CH0, {16'h0, v[0]}, 32'hffff);
    setc(v[2]);
    u_pin.drive(1'b1, 8);
    setc(v[3]);
    u_pin.drive(1'b0, 8);
    rd(OFS_CH1, {16'h0, v[1]}, 32'hffff);
    rd(OFS_CH0, {16'h0, v[2]}, 32'hffff);
    rd(OFS_CH1, {16'h0, v[3]}, 32'hffff);
    $display("test capture done");
    repeat (4) @(posedge clk);
    tally_and_finish();
  end
endmodule
